// ==== src/dcp_pkg.sv ====
package dcp_pkg;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CHAN_ID = 8'h00;
    localparam logic [7:0] OFS_PRX_MEM = 8'h04;
    localparam logic [7:0] OFS_PRX_PER = 8'h08;
    localparam logic [7:0] OFS_PRX_CNT = 8'h0C;
    localparam logic [7:0] OFS_PRX_CTL = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // ****************************************
    // context entry layout
    // ****************************************
    localparam int ENTRY_W = 128;
    localparam int WORD_W = 32;
    localparam int PRX_NUM = 4;
    localparam int PRX_MEM = 0;
    localparam int PRX_PER = 1;
    localparam int PRX_CNT = 2;
    localparam int PRX_CTL = 3;
    // ****************************************
    // transfer control word fields
    // ****************************************
    localparam int CTL_EN_BIT = 31;
    localparam int CTL_IE_BIT = 30;
    localparam int CTL_IMOD_BIT = 29;
    localparam int CTL_SINT_LSB = 26;
    localparam int SINT_W = 3;
    localparam int IRQ_LINES = 8;
    localparam int SIZE_W = 16;
    localparam int GROUPS = 2;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [1:0] MODE_RST = 2'h0;
    // pipeline depth from bus ready to interrupt pulse
    localparam int IRQ_LAT = 2;
endpackage : dcp_pkg

// ==== src/dcp_top.sv ====
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module dcp_top #(
    parameter int NCH = 8,
    parameter int NCORE = 2,
    parameter int CH_W = $clog2(NCH),
    parameter int CORE_W = (NCORE > 1) ? $clog2(NCORE) : 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [CORE_W-1:0] bus_core,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic [NCH-1:0] evt_pulse,
    output logic svc_vld,
    output logic [CH_W-1:0] svc_ch,
    input wire logic [CH_W-1:0] eng_rd_ch,
    output logic [dcp_pkg::ENTRY_W-1:0] eng_ctx,
    input wire logic done_vld,
    input wire logic [CH_W-1:0] done_ch,
    input wire logic [dcp_pkg::SIZE_W-1:0] done_cnt,
    output logic [dcp_pkg::IRQ_LINES-1:0] irq_g0,
    output logic [CH_W-1:0] irq_id_g0,
    output logic [dcp_pkg::IRQ_LINES-1:0] irq_g1,
    output logic [CH_W-1:0] irq_id_g1
);
    import dcp_pkg::*;

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [31:0] entry_word(
        input logic [ENTRY_W-1:0] e, input int idx);
        entry_word = e[idx*WORD_W +: WORD_W];
    endfunction : entry_word

    function automatic logic irq_hit(input logic [31:0] ctl,
        input logic [31:0] cnt_word, input logic [SIZE_W-1:0] cnt,
        input logic abu);
        logic [SIZE_W-1:0] size;
        size = cnt_word[SIZE_W-1:0];
        if (!ctl[CTL_IE_BIT]) begin
            irq_hit = 1'b0;
        end else if (abu) begin
            irq_hit = (cnt == size) ||
                (ctl[CTL_IMOD_BIT] && cnt == (size >> 1));
        end else begin
            irq_hit = (cnt == size);
        end
    endfunction : irq_hit

    // ****************************************
    // state
    // ****************************************
    logic [ENTRY_W-1:0] ctx_ff [NCH];
    logic [CH_W-1:0] chid_ff [NCORE];
    logic [31:0] prx_ff [NCORE][PRX_NUM];
    logic [1:0] mode_ff;
    logic discard_ff;
    logic [NCH-1:0] pend_ff;
    logic [31:0] rdata_ff;
    logic svc_vld_ff;
    logic [CH_W-1:0] svc_ch_ff;
    logic [ENTRY_W-1:0] eng_ctx_ff;
    logic st1_vld_ff;
    logic [CH_W-1:0] st1_ch_ff;
    logic [SINT_W-1:0] st1_sint_ff;
    logic [IRQ_LINES-1:0] irq_g0_ff;
    logic [IRQ_LINES-1:0] irq_g1_ff;
    logic [CH_W-1:0] irq_id_g0_ff;
    logic [CH_W-1:0] irq_id_g1_ff;

    // ****************************************
    // decode
    // ****************************************
    logic [CH_W-1:0] sel_ch;
    logic [ENTRY_W-1:0] sel_entry;
    logic sel_run;
    logic commit;
    logic commit_ok;
    logic load_prx;
    logic [ENTRY_W-1:0] new_entry;
    // each core owns its own channel id and proxy set, so another
    // core's accesses can never tear a sequence in progress
    assign sel_ch = chid_ff[bus_core];
    assign sel_entry = ctx_ff[sel_ch];
    assign sel_run = sel_entry[3*WORD_W + CTL_EN_BIT];
    assign commit = bus_wr && bus_addr == OFS_PRX_CTL;
    // a commit to a running channel is taken only if it clears the enable bit
    assign commit_ok = !sel_run || !bus_wdata[CTL_EN_BIT];
    assign load_prx = bus_rd && bus_addr == OFS_PRX_MEM;
    assign new_entry = {bus_wdata, prx_ff[bus_core][PRX_CNT],
        prx_ff[bus_core][PRX_PER], prx_ff[bus_core][PRX_MEM]};

    // ****************************************
    // proxy and channel id registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int c = 0; c < NCORE; c++) begin
                chid_ff[c] <= '0;
                for (int p = 0; p < PRX_NUM; p++) begin
                    prx_ff[c][p] <= WORD_RST;
                end
            end
        end else if (bus_wr) begin
            case (bus_addr)
                OFS_CHAN_ID: chid_ff[bus_core] <= bus_wdata[CH_W-1:0];
                OFS_PRX_MEM: prx_ff[bus_core][PRX_MEM] <= bus_wdata;
                OFS_PRX_PER: prx_ff[bus_core][PRX_PER] <= bus_wdata;
                OFS_PRX_CNT: prx_ff[bus_core][PRX_CNT] <= bus_wdata;
                OFS_PRX_CTL: prx_ff[bus_core][PRX_CTL] <= bus_wdata;
                default: ;
            endcase
        end else if (load_prx) begin
            for (int p = 0; p < PRX_NUM; p++) begin
                prx_ff[bus_core][p] <= entry_word(sel_entry, p);
            end
        end
    end

    // ****************************************
    // context memory
    // ****************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < NCH; i++) begin
                ctx_ff[i] <= '0;
            end
        end else if (commit && commit_ok) begin
            ctx_ff[sel_ch] <= new_entry;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            discard_ff <= 1'b0;
        end else if (commit) begin
            discard_ff <= !commit_ok;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_ff <= MODE_RST;
        end else if (bus_wr && bus_addr == OFS_MODE) begin
            mode_ff <= bus_wdata[GROUPS-1:0];
        end
    end

    // ****************************************
    // read data
    // ****************************************
    // the entry is copied into the proxies on the same edge that
    // registers the first word, so the next three proxy reads may
    // follow back to back with no wait
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_ff <= WORD_RST;
        end else if (bus_rd) begin
            case (bus_addr)
                OFS_CHAN_ID: rdata_ff <= 32'(sel_ch);
                OFS_PRX_MEM: rdata_ff <= entry_word(sel_entry, PRX_MEM);
                OFS_PRX_PER: rdata_ff <= prx_ff[bus_core][PRX_PER];
                OFS_PRX_CNT: rdata_ff <= prx_ff[bus_core][PRX_CNT];
                OFS_PRX_CTL: rdata_ff <= prx_ff[bus_core][PRX_CTL];
                OFS_MODE: rdata_ff <= 32'(mode_ff);
                OFS_STATUS: rdata_ff <= {15'h0000, discard_ff,
                    16'(pend_ff)};
                default: rdata_ff <= WORD_RST;
            endcase
        end else begin
            rdata_ff <= WORD_RST;
        end
    end

    // ****************************************
    // event holding and service
    // ****************************************
    logic [NCH-1:0] ready_ev;
    logic pick_vld;
    logic [CH_W-1:0] pick_ch;
    always_comb begin
        pick_vld = 1'b0;
        pick_ch = '0;
        for (int i = 0; i < NCH; i++) begin
            ready_ev[i] = pend_ff[i] && ctx_ff[i][3*WORD_W + CTL_EN_BIT];
        end
        for (int i = NCH - 1; i >= 0; i--) begin
            if (ready_ev[i]) begin
                pick_vld = 1'b1;
                pick_ch = CH_W'(i);
            end
        end
    end

    // a new event on the channel being served wins over the clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend_ff <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (evt_pulse[i]) begin
                    pend_ff[i] <= 1'b1;
                end else if (pick_vld && pick_ch == CH_W'(i)) begin
                    pend_ff[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            svc_vld_ff <= 1'b0;
            svc_ch_ff <= '0;
        end else begin
            svc_vld_ff <= pick_vld;
            svc_ch_ff <= pick_vld ? pick_ch : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            eng_ctx_ff <= '0;
        end else begin
            eng_ctx_ff <= ctx_ff[eng_rd_ch];
        end
    end

    // ****************************************
    // interrupt generation
    // ****************************************
    logic [ENTRY_W-1:0] done_entry;
    logic done_hit;
    logic done_grp;
    assign done_entry = ctx_ff[done_ch];
    assign done_grp = done_ch[CH_W-1];
    assign done_hit = done_vld && irq_hit(entry_word(done_entry, PRX_CTL),
        entry_word(done_entry, PRX_CNT), done_cnt, mode_ff[done_grp]);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st1_vld_ff <= 1'b0;
            st1_ch_ff <= '0;
            st1_sint_ff <= '0;
        end else begin
            st1_vld_ff <= done_hit;
            st1_ch_ff <= done_ch;
            st1_sint_ff <= done_entry[3*WORD_W + CTL_SINT_LSB +: SINT_W];
        end
    end

    // only one stage feeds these, so each done_hit gives a pulse of one cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_g0_ff <= '0;
            irq_g1_ff <= '0;
            irq_id_g0_ff <= '0;
            irq_id_g1_ff <= '0;
        end else begin
            irq_g0_ff <= '0;
            irq_g1_ff <= '0;
            irq_id_g0_ff <= '0;
            irq_id_g1_ff <= '0;
            if (st1_vld_ff && !st1_ch_ff[CH_W-1]) begin
                irq_g0_ff <= IRQ_LINES'(1) << st1_sint_ff;
                irq_id_g0_ff <= st1_ch_ff;
            end
            if (st1_vld_ff && st1_ch_ff[CH_W-1]) begin
                irq_g1_ff <= IRQ_LINES'(1) << st1_sint_ff;
                irq_id_g1_ff <= st1_ch_ff;
            end
        end
    end

    assign bus_rdata = rdata_ff;
    assign svc_vld = svc_vld_ff;
    assign svc_ch = svc_ch_ff;
    assign eng_ctx = eng_ctx_ff;
    assign irq_g0 = irq_g0_ff;
    assign irq_g1 = irq_g1_ff;
    assign irq_id_g0 = irq_id_g0_ff;
    assign irq_id_g1 = irq_id_g1_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [CH_W-1:0] chk_ch_ff;
    logic [ENTRY_W-1:0] chk_old_ff;
    logic [NCH-1:0] held_ff;
    always_ff @(posedge clk) begin
        chk_ch_ff <= sel_ch;
        chk_old_ff <= sel_entry;
        // events waiting on a stopped channel; none of them may vanish
        held_ff <= pend_ff & ~ready_ev;
    end

    irq_delay_a: assert property (done_hit |-> ##2
        ((irq_g0_ff | irq_g1_ff) != '0))
        else $error("interrupt not two cycles after bus ready");
    irq_pulse_a: assert property ($onehot0(irq_g0_ff) &&
        $onehot0(irq_g1_ff))
        else $error("more than one interrupt line active");
    irq_id_a: assert property (((irq_g0_ff != '0) ||
        (irq_g1_ff != '0)) |-> (irq_id_g0_ff | irq_id_g1_ff) ==
        $past(done_ch, 2))
        else $error("identifier does not match interrupt");
    no_ie_a: assert property (done_vld &&
        !done_entry[3*WORD_W + CTL_IE_BIT] |-> ##2
        (irq_g0_ff == '0 && irq_g1_ff == '0))
        else $error("interrupt with enable clear");
    run_guard_a: assert property (commit && sel_run &&
        bus_wdata[CTL_EN_BIT] |=> ctx_ff[chk_ch_ff] == chk_old_ff)
        else $error("running channel was reprogrammed");
    idle_commit_a: assert property (commit && !sel_run |=>
        ctx_ff[chk_ch_ff][ENTRY_W-1 -: WORD_W] == $past(bus_wdata))
        else $error("commit to stopped channel lost");
    read_back_a: assert property (load_prx |=>
        bus_rdata == chk_old_ff[WORD_W-1:0])
        else $error("first proxy read wrong");
    pend_hold_a: assert property (held_ff != '0 |->
        (pend_ff & held_ff) == held_ff)
        else $error("pending event dropped");
    discard_flag_a: assert property (commit |=>
        discard_ff != $past(commit_ok))
        else $error("discard status wrong");
    rdata_idle_a: assert property (!bus_rd |=>
        rdata_ff == '0)
        else $error("read data outside its cycle");
    irq_width_a: assert property (((irq_g0_ff | irq_g1_ff) != '0) &&
        !$past(done_hit) |=> ((irq_g0_ff | irq_g1_ff) == '0))
        else $error("interrupt pulse longer than one cycle");
    id0_idle_a: assert property (irq_g0_ff == '0 |->
        irq_id_g0_ff == '0)
        else $error("group 0 identifier without pulse");
    id1_idle_a: assert property (irq_g1_ff == '0 |->
        irq_id_g1_ff == '0)
        else $error("group 1 identifier without pulse");
    grp0_id_a: assert property (irq_g0_ff != '0 |->
        !irq_id_g0_ff[CH_W-1])
        else $error("group 0 pulse for group 1 channel");
    grp1_id_a: assert property (irq_g1_ff != '0 |->
        irq_id_g1_ff[CH_W-1])
        else $error("group 1 pulse for group 0 channel");
endmodule : dcp_top
`default_nettype wire

// ==== testbench/dcp_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// processor cores: one bus master shared by all cores
// ****************************************
module dcp_core_model #(
    parameter int CORE_W = 1
) (
    input wire logic clk,
    output logic [CORE_W-1:0] bus_core,
    output logic [7:0] bus_addr,
    output logic [31:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input wire logic [31:0] bus_rdata
);
    logic [31:0] rq [4];
    initial begin
        bus_core = '0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0000_0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    task automatic wr(input int c, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_core <= CORE_W'(c);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        // released data must not keep looking valid
        bus_wdata <= ~d;
    endtask : wr
    // n reads on consecutive cycles from a, a+4, ...
    task automatic rd(input int c, input logic [7:0] a, input int n);
        for (int i = 0; i < n + 2; i++) begin
            @(posedge clk);
            if (i > 1) begin
                rq[i-2] = bus_rdata;
            end
            bus_core <= CORE_W'(c);
            bus_addr <= a + 8'(4 * i);
            bus_rd <= (i < n);
        end
    endtask : rd
endmodule : dcp_core_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dcp_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic bus_core;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] bus_rdata;
    logic [7:0] evt_pulse = 8'h00;
    logic svc_vld;
    logic [2:0] svc_ch;
    logic [2:0] eng_rd_ch = 3'h0;
    logic [127:0] eng_ctx;
    logic done_vld = 1'b0;
    logic [2:0] done_ch = 3'h0;
    logic [15:0] done_cnt = 16'h0000;
    logic [7:0] irq_g0;
    logic [7:0] irq_g1;
    logic [2:0] irq_id_g0;
    logic [2:0] irq_id_g1;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'hace3533d;
    always #50 clk = ~clk;
    dcp_top dcp_top_inst (.clk(clk), .nrst(nrst), .bus_core(bus_core),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .evt_pulse(evt_pulse),
        .svc_vld(svc_vld), .svc_ch(svc_ch), .eng_rd_ch(eng_rd_ch),
        .eng_ctx(eng_ctx), .done_vld(done_vld), .done_ch(done_ch),
        .done_cnt(done_cnt), .irq_g0(irq_g0), .irq_id_g0(irq_id_g0),
        .irq_g1(irq_g1), .irq_id_g1(irq_id_g1));
    dcp_core_model dcp_core_model_inst (.clk(clk), .bus_core(bus_core),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata));
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string nm, input logic [127:0] e,
        input logic [127:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    // whole run is well under a thousand cycles; this only cuts a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            results();
        end
    end
    function automatic logic irq_due(input logic [31:0] ctl,
        input logic [15:0] sz, input logic [15:0] cnt, input logic abu);
        return ctl[CTL_IE_BIT] && (cnt == sz ||
            (abu && ctl[CTL_IMOD_BIT] && cnt == (sz >> 1)));
    endfunction : irq_due
    task automatic prog(input int c, input int ch, input logic [127:0] e);
        dcp_core_model_inst.wr(c, OFS_CHAN_ID, 32'(ch));
        dcp_core_model_inst.wr(c, OFS_PRX_MEM, e[31:0]);
        dcp_core_model_inst.wr(c, OFS_PRX_PER, e[63:32]);
        dcp_core_model_inst.wr(c, OFS_PRX_CNT, e[95:64]);
        dcp_core_model_inst.wr(c, OFS_PRX_CTL, e[127:96]);
    endtask : prog
    task automatic rback(input int c, input logic [127:0] e);
        dcp_core_model_inst.rd(c, OFS_PRX_MEM, 4);
        chk("entry", e, {dcp_core_model_inst.rq[3],
            dcp_core_model_inst.rq[2], dcp_core_model_inst.rq[1],
            dcp_core_model_inst.rq[0]});
    endtask : rback
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [127:0] e;
        logic [127:0] f;
        logic [31:0] ctl;
        logic [15:0] sz;
        logic [15:0] cnt;
        logic [7:0] ln;
        logic [7:0] xl;
        logic hit;
        int ch;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rback(0, 128'h0);
        dcp_core_model_inst.rd(0, 8'h1C, 1);
        chk("unmapped", 0, dcp_core_model_inst.rq[0]);
        e = {$random(seed), $random(seed), $random(seed), $random(seed)};
        f = {$random(seed), $random(seed), $random(seed), $random(seed)};
        e[127] = 1'b0;
        f[127] = 1'b0;
        dcp_core_model_inst.wr(0, OFS_CHAN_ID, 32'h0000_0003);
        dcp_core_model_inst.wr(0, OFS_PRX_MEM, e[31:0]);
        dcp_core_model_inst.wr(0, OFS_PRX_PER, e[63:32]);
        prog(1, 1, f);
        dcp_core_model_inst.wr(0, OFS_PRX_CNT, e[95:64]);
        dcp_core_model_inst.wr(0, OFS_PRX_CTL, e[127:96]);
        rback(0, e);
        rback(1, f);
        eng_rd_ch <= 3'h3;
        repeat (2) @(posedge clk);
        chk("eng_ctx", e, eng_ctx);
        e[127] = 1'b1;
        dcp_core_model_inst.wr(0, OFS_PRX_CTL, e[127:96]);
        rback(0, e);
        f[127] = 1'b1;
        prog(0, 3, f);
        rback(0, e);
        dcp_core_model_inst.rd(0, OFS_STATUS, 1);
        chk("discard", 1, 128'(dcp_core_model_inst.rq[0][16]));
        dcp_core_model_inst.rd(0, OFS_CHAN_ID, 1);
        chk("chan_id", 3, dcp_core_model_inst.rq[0]);
        f[127] = 1'b0;
        prog(0, 3, f);
        rback(0, f);
        // event on a stopped channel waits for it to be enabled
        evt_pulse <= 8'h40;
        @(posedge clk);
        evt_pulse <= 8'h00;
        hit = 1'b0;
        repeat (6) @(posedge clk) hit |= svc_vld;
        chk("held", 0, 128'(hit));
        e[127] = 1'b1;
        prog(1, 6, e);
        hit = 1'b0;
        for (int i = 0; i < 8 && hit !== 1'b1; i++) begin
            @(posedge clk);
            hit = svc_vld;
        end
        chk("svc", 1, 128'(hit));
        chk("svc_ch", 6, 128'(svc_ch));
        for (int k = 0; k < 32; k++) begin
            ch = {$random(seed)} % 5;
            ch = (ch == 3) ? 7 : ch;
            sz = 16'h0010 + 16'(2 * ({$random(seed)} % 50));
            cnt = (k[3:2] == 2'd0) ? sz : (k[3:2] == 2'd2) ? sz - 16'h1 :
                (sz >> 1) + 16'(k[3]);
            ctl = $random(seed);
            ctl[CTL_EN_BIT] = 1'b0;
            ctl[CTL_IE_BIT] = ~(k[4] & k[2]);
            ctl[CTL_IMOD_BIT] = k[1];
            ctl[28:26] = 3'(k * 3);
            dcp_core_model_inst.wr(0, OFS_MODE, {30'h0, k[0], k[0]});
            prog(0, ch, {ctl, 16'h0000, sz, 64'(f)});
            @(posedge clk);
            done_vld <= 1'b1;
            done_ch <= 3'(ch);
            done_cnt <= cnt;
            @(posedge clk);
            done_vld <= 1'b0;
            hit = irq_due(ctl, sz, cnt, k[0]);
            ln = hit ? 8'(1 << ctl[28:26]) : 8'h00;
            for (int j = 0; j < 3; j++) begin
                @(posedge clk);
                xl = (j == 1) ? ln : 8'h00;
                chk("irq_g0", ch < 4 ? xl : 8'h00, irq_g0);
                chk("irq_g1", ch > 3 ? xl : 8'h00, irq_g1);
                chk("irq_id", (j == 1 && hit) ? ch : 0,
                    ch > 3 ? irq_id_g1 : irq_id_g0);
            end
        end
        dcp_core_model_inst.rd(1, OFS_MODE, 1);
        chk("mode", 3, dcp_core_model_inst.rq[0]);
        results();
    end
endmodule : tb
`default_nettype wire
